/* File: cfg_wdt_regs.vh */
/*
 Constants for the configuration word decoder and watchdog:
 word location, field positions, codes and timing figures.
 Assumes inclusion by the design files only; definitions only.
*/
`ifndef CFG_WDT_REGS_VH
`define CFG_WDT_REGS_VH

// Configuration word location and test space bounds
`define CFG_WORD_ADDR 14'h2007
`define CFG_SPACE_LO 14'h2000
`define CFG_SPACE_HI 14'h3FFF
`define CFG_WIDTH 14
`define CFG_ERASED 14'h3FFF

// Field positions
`define CFG_CP_A_HI 13
`define CFG_CP_A_LO 12
`define CFG_CP_B_HI 11
`define CFG_CP_B_LO 10
`define CFG_CP_C_HI 9
`define CFG_CP_C_LO 8
`define CFG_UNUSED_BIT 7
`define CFG_BOR_BIT 6
`define CFG_CP_D_HI 5
`define CFG_CP_D_LO 4
`define CFG_POWERUP_DELAY_TIMER_BIT 3
`define CFG_WATCHDOG_ENABLE_FUSE_BIT 2
`define CFG_OSC_HI 1
`define CFG_OSC_LO 0

// Code protection pair codes
`define CP_NONE 2'h3
`define CP_UPPER_HALF 2'h2
`define CP_UPPER_3Q 2'h1
`define CP_ALL 2'h0

// Program memory size selects
`define MEM_2K 2'h0
`define MEM_1K 2'h1
`define MEM_HALF_K 2'h2

// Protected range bounds
`define PROT_0000 11'h000
`define PROT_0200 11'h200
`define PROT_0400 11'h400
`define PROT_01FF 11'h1FF
`define PROT_03FF 11'h3FF
`define PROT_07FF 11'h7FF

// Oscillator select codes
`define OSC_RC 2'h3
`define OSC_HS 2'h2
`define OSC_XT 2'h1
`define OSC_LP 2'h0

// Watchdog period and prescale limit
`define WDT_PERIOD_US 18000
`define WDT_PRESCALE_MAX 3'h7

`endif

/* File: cfg_word_store.v */
/*
 One-time configuration word store. Holds the word, erased to
 all ones; a write can only program bits to zero.
 Assumes the top gates writes by programming mode and address.
*/
`timescale 1ns/1ps
`include "cfg_wdt_regs.vh"

module cfg_word_store #(
  parameter WIDTH = `CFG_WIDTH
)(
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Write side
  input wire wr_en,
  input wire [WIDTH-1:0] wr_data,
  // Stored word
  output reg [WIDTH-1:0] word_q
);

  // Programming only clears bits, like real fuse cells
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      word_q <= `CFG_ERASED;
    else if (wr_en)
      word_q <= word_q & wr_data;
  end

endmodule

/* File: config_word_and_watchdog.v */
/*
 Configuration word decoder and watchdog timer.
 Assumes the core supplies sleep and clear-watchdog strobes on clk,
 and the watchdog oscillator arrives as an asynchronous pin.
 Decoded outputs lag the stored word by one clock.
*/
// Contract
// R1 - Configuration word sits at address 2007h outside user program space.
// R2 - Programmed bits read 0, unprogrammed bits read 1.
// R3 - Space 2000h-3FFFh reachable only in programming mode.
// R4 - 2K memory: pair 11 none, 10 400-7FF, 01 200-7FF, 00 all.
// R5 - 1K memory: pair 11 unprotected, 01 protects 0200h-03FFh.
// R6 - 0.5K memory: only pair 00 protects 0000h-01FFh.
// R7 - Programmer writes the same value to every protection pair.
// R8 - Bit 7 unimplemented, always reads as 1.
// R9 - Bit 6 set enables brown-out reset detection.
// R10 - Bit 3 low enables the power-up delay timer.
// R11 - Brown-out enable forces the power-up delay timer on.
// R12 - Bit 2 enables watchdog; clear disables it permanently.
// R13 - Bits 1-0: 11 RC, 10 high-speed crystal, 01 standard crystal.
// R14 - Watchdog counts its own oscillator, running through sleep.
// R15 - Timeout in normal operation causes a full device reset.
// R16 - Timeout during sleep wakes the device instead of resetting.
// R17 - Unscaled timeout is nominally 18 ms of watchdog oscillator.
// R18 - Prescaler up to 1:128 may extend the timeout.
// R19 - Clear-watchdog or sleep clears counter and assigned prescaler.
// R20 - Every timeout clears the timeout flag.
// R21 - Oscillator code 00 selects low-power crystal.
// R22 - Disabled watchdog gives no reset, no wake, flag unchanged.
`timescale 1ns/1ps
`include "cfg_wdt_regs.vh"

module config_word_and_watchdog #(
  parameter WIDTH = `CFG_WIDTH,
  parameter WDT_OSC_KHZ = 1000,
  parameter WDT_BASE_TICKS = (`WDT_PERIOD_US * WDT_OSC_KHZ) / 1000,
  parameter CNT_W = 16
)(
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Programming port
  input wire prog_mode,
  input wire [13:0] prog_addr,
  input wire prog_wr,
  input wire [WIDTH-1:0] prog_wdata,
  output reg [WIDTH-1:0] prog_rdata,
  output reg prog_rvalid,
  // Program memory protection query
  input wire [1:0] mem_size,
  input wire [10:0] fetch_addr,
  output reg addr_protected,
  // Decoded configuration
  output reg brownout_reset_enable,
  output reg powerup_delay_timer_on,
  output reg watchdog_enable_fuse,
  output reg high_speed_crystal_mode,
  output reg standard_crystal_mode,
  output reg low_power_crystal_mode,
  output reg rc_osc_mode,
  // Watchdog control
  input wire wdt_osc_pin,
  input wire sleeping,
  input wire clear_watchdog_instr,
  input wire sleep_instr,
  input wire prescaler_to_wdt,
  input wire [2:0] prescale_sel,
  input wire timeout_flag_set,
  // Watchdog results
  output reg wdt_reset,
  output reg wdt_wake,
  output reg timeout_flag_n
);

  // Four protection pairs live in the word
  localparam N_PAIRS = 4;

  wire [WIDTH-1:0] word_q;
  wire cfg_hit;
  wire [WIDTH-1:0] read_word;
  wire [1:0] pair_a;
  wire pairs_match;
  reg [2:0] osc_sync_q;
  reg [7:0] pre_q;
  reg [CNT_W-1:0] cnt_q;
  reg [CNT_W-1:0] cnt_d;
  reg tick_en;
  reg wdt_clear;
  reg timeout;
  wire [1:0] osc_code;
  wire [2*N_PAIRS-3:0] cp_others;
  wire [N_PAIRS-2:0] pair_eq;
  wire pre_due;

  // Protection check for one memory size; used per pair code
  function prot_hit;
    input [1:0] size;
    input [1:0] code;
    input [10:0] a;
    begin
      prot_hit = 1'b0;
      case (size)
        `MEM_2K:
          case (code)
            `CP_UPPER_HALF: prot_hit = (a >= `PROT_0400) && (a <= `PROT_07FF); // R4
            `CP_UPPER_3Q: prot_hit = (a >= `PROT_0200) && (a <= `PROT_07FF); // R4
            `CP_ALL: prot_hit = (a <= `PROT_07FF); // R4
            default: prot_hit = 1'b0;
          endcase
        `MEM_1K:
          case (code)
            `CP_UPPER_HALF: prot_hit = (a <= `PROT_03FF);
            `CP_UPPER_3Q: prot_hit = (a >= `PROT_0200) && (a <= `PROT_03FF); // R5
            `CP_ALL: prot_hit = (a <= `PROT_03FF);
            default: prot_hit = 1'b0; // R5
          endcase
        `MEM_HALF_K:
          prot_hit = (code == `CP_ALL) && (a <= `PROT_01FF); // R6
        // Sizes outside the three listed never protect
        default:
          prot_hit = 1'b0;
      endcase
    end
  endfunction

  // Prescaler output: every 2^sel watchdog ticks, low sel bits all ones
  function pre_hit;
    input [7:0] cnt;
    input [2:0] sel;
    reg [7:0] mask;
    begin
      mask = (8'h01 << sel) - 8'h01;
      pre_hit = (cnt & mask) == mask; // R18
    end
  endfunction

  // Config location and test space only decode in programming mode;
  // the word is the only location implemented inside the test space
  assign cfg_hit = prog_mode && (prog_addr == `CFG_WORD_ADDR); // R1 R3

  // One-time word store; bits can only be programmed to zero
  cfg_word_store #(
    .WIDTH(WIDTH)
  ) u_store (
    .clk(clk),
    .nrst(nrst),
    .wr_en(prog_wr && cfg_hit),
    .wr_data(prog_wdata),
    .word_q(word_q)
  );

  // Unimplemented bit forced high on readback
  assign read_word = word_q | ({{(WIDTH-1){1'b0}}, 1'b1} << `CFG_UNUSED_BIT); // R8 R2

  // Protection scheme only counts when all pairs agree; a half-burned
  // word therefore leaves memory open rather than partly locked
  assign pair_a = word_q[`CFG_CP_A_HI:`CFG_CP_A_LO];
  assign cp_others = {word_q[`CFG_CP_B_HI:`CFG_CP_B_LO], word_q[`CFG_CP_C_HI:`CFG_CP_C_LO],
                      word_q[`CFG_CP_D_HI:`CFG_CP_D_LO]};

  // One comparator per remaining pair against the first
  genvar gi;
  generate
    for (gi = 0; gi < N_PAIRS - 1; gi = gi + 1)
    begin : g_pair
      assign pair_eq[gi] = (cp_others[2*gi+1:2*gi] == pair_a); // R7
    end
  endgenerate

  assign pairs_match = &pair_eq; // R7

  // Oscillator select field, decoded one-hot below
  assign osc_code = word_q[`CFG_OSC_HI:`CFG_OSC_LO];

  // Programming readback; test space outside mode reads nothing
  // Zero data on a miss keeps a refused read from leaking the word
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      prog_rdata <= {WIDTH{1'b0}};
      prog_rvalid <= 1'b0;
    end
    else
    begin
      prog_rvalid <= cfg_hit && !prog_wr; // R3
      prog_rdata <= cfg_hit ? read_word : {WIDTH{1'b0}};
    end
  end

  // Registered decode of configuration fields; one clock of lag buys
  // glitch-free levels for the reset and clock generators downstream
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      addr_protected <= 1'b0;
      brownout_reset_enable <= 1'b0;
      powerup_delay_timer_on <= 1'b0;
      watchdog_enable_fuse <= 1'b0;
      high_speed_crystal_mode <= 1'b0;
      standard_crystal_mode <= 1'b0;
      low_power_crystal_mode <= 1'b0;
      rc_osc_mode <= 1'b0;
    end
    else
    begin
      addr_protected <= pairs_match && prot_hit(mem_size, pair_a, fetch_addr);
      brownout_reset_enable <= word_q[`CFG_BOR_BIT]; // R9
      powerup_delay_timer_on <= !word_q[`CFG_POWERUP_DELAY_TIMER_BIT] || word_q[`CFG_BOR_BIT]; // R10 R11
      watchdog_enable_fuse <= word_q[`CFG_WATCHDOG_ENABLE_FUSE_BIT]; // R12
      rc_osc_mode <= (osc_code == `OSC_RC); // R13
      high_speed_crystal_mode <= (osc_code == `OSC_HS); // R13
      standard_crystal_mode <= (osc_code == `OSC_XT); // R13
      low_power_crystal_mode <= (osc_code == `OSC_LP); // R21
    end
  end

  // Watchdog oscillator synchroniser; third stage only for edge detect.
  // The oscillator must stay well below clk/4, or ticks merge and are
  // lost; the sync adds about three clk of latency to every tick, which
  // is negligible against a timeout of thousands of ticks
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      osc_sync_q <= 3'h0;
    else
      osc_sync_q <= {osc_sync_q[1:0], wdt_osc_pin};
  end

  // Rising edge of the independent oscillator; sleep does not gate it
  always @*
  begin
    tick_en = osc_sync_q[1] && !osc_sync_q[2]; // R14
    wdt_clear = clear_watchdog_instr || sleep_instr; // R19
  end

  // Prescaler: 1:1 when not assigned, else 1:2^(sel) up to 1:128
  // Cleared only when assigned, since it may be serving the timer side
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      pre_q <= 8'h00;
    else if (wdt_clear && prescaler_to_wdt)
      pre_q <= 8'h00; // R19
    else if (tick_en)
      pre_q <= pre_q + 8'h01;
  end

  // Prescaled tick; 1:1 while the prescaler is not assigned here
  assign pre_due = !prescaler_to_wdt || pre_hit(pre_q, prescale_sel); // R18

  // Counter advance on the prescaled tick; a clear always wins.
  // A blown fuse holds the count at zero, so no event can ever fire
  always @*
  begin
    cnt_d = cnt_q;
    timeout = 1'b0;
    if (wdt_clear || !watchdog_enable_fuse)
      cnt_d = {CNT_W{1'b0}}; // R19 R22
    else if (tick_en && pre_due) // R18
    begin
      if (cnt_q == WDT_BASE_TICKS[CNT_W-1:0] - 1'b1)
      begin
        cnt_d = {CNT_W{1'b0}};
        timeout = 1'b1; // R17
      end
      else
        cnt_d = cnt_q + 1'b1;
    end
  end

  // Watchdog count register
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      cnt_q <= {CNT_W{1'b0}};
    else
      cnt_q <= cnt_d;
  end

  // Timeout effects; flag clear beats a software set in the same cycle.
  // Reset and wake are one-clock pulses; the core must stretch them if
  // its reset tree needs a longer assertion
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wdt_reset <= 1'b0;
      wdt_wake <= 1'b0;
      timeout_flag_n <= 1'b1;
    end
    else
    begin
      wdt_reset <= timeout && !sleeping; // R15 R22
      wdt_wake <= timeout && sleeping; // R16 R22
      if (timeout)
        timeout_flag_n <= 1'b0; // R20
      else if (timeout_flag_set)
        timeout_flag_n <= 1'b1;
    end
  end

endmodule

/* File: cfg_wdt_monitor.sv */
/*
 Checker for the configuration decoder and watchdog.
 Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
module cfg_wdt_monitor (
  // Clock and reset
  input wire clk, nrst,
  // Programming port
  input wire prog_mode, prog_wr, prog_rvalid,
  input wire [13:0] prog_addr, prog_rdata,
  // Protection query
  input wire [1:0] mem_size,
  input wire [10:0] fetch_addr,
  input wire addr_protected,
  // Decoded configuration
  input wire brownout_reset_enable, powerup_delay_timer_on, watchdog_enable_fuse,
  input wire high_speed_crystal_mode, standard_crystal_mode, low_power_crystal_mode, rc_osc_mode,
  // Watchdog
  input wire sleeping, wdt_reset, wdt_wake, timeout_flag_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Readback only for a programming-mode read of the word
  read_gate_a: assert property (prog_rvalid |-> $past(prog_mode) && $past(prog_addr) == 14'h2007
    && !$past(prog_wr)) else $error("readback without a valid read");
  bit_seven_a: assert property (prog_rvalid |-> prog_rdata[7]) else $error("bit 7 read low");
  half_k_a: assert property ($past(mem_size) == 2'h2 && $past(fetch_addr) > 11'h1FF |-> !addr_protected)
    else $error("protection above small memory");
  bor_powerup_delay_timer_a: assert property (brownout_reset_enable |-> powerup_delay_timer_on)
    else $error("brown-out without delay timer");
  osc_onehot_a: assert property ($past(nrst) |-> $onehot({high_speed_crystal_mode, standard_crystal_mode,
    low_power_crystal_mode, rc_osc_mode})) else $error("oscillator mode not one-hot");
  // Events are one-cycle pulses tied to the sleep state
  reset_pulse_a: assert property (wdt_reset |=> !wdt_reset) else $error("reset pulse too long");
  reset_awake_a: assert property (wdt_reset |-> !$past(sleeping)) else $error("reset while asleep");
  wake_asleep_a: assert property (wdt_wake |-> $past(sleeping)) else $error("wake while awake");
  flag_clear_a: assert property (wdt_reset || wdt_wake |-> !timeout_flag_n)
    else $error("timeout flag not cleared");
  fuse_off_a: assert property (!watchdog_enable_fuse && !$past(watchdog_enable_fuse)
    |-> !wdt_reset && !wdt_wake) else $error("event with watchdog off");
endmodule
bind config_word_and_watchdog cfg_wdt_monitor mon (.clk, .nrst, .prog_mode, .prog_wr, .prog_rvalid,
  .prog_addr, .prog_rdata, .mem_size, .fetch_addr, .addr_protected, .brownout_reset_enable,
  .powerup_delay_timer_on, .watchdog_enable_fuse, .high_speed_crystal_mode, .standard_crystal_mode,
  .low_power_crystal_mode, .rc_osc_mode, .sleeping, .wdt_reset, .wdt_wake, .timeout_flag_n);

/* File: cfg_programmer.sv */
/*
 Device programmer model driving the programming port.
 Assumes one clock shared with the block; one access at a time.
*/
`timescale 1ns/1ps
module cfg_programmer (
  // Clock and readback
  input wire clk, prog_rvalid,
  input wire [13:0] prog_rdata,
  // Programming strobes
  output logic prog_mode, prog_wr,
  output logic [13:0] prog_addr, prog_wdata
);
  initial {prog_mode, prog_wr, prog_addr, prog_wdata} = '0;
  // One access; released lines scramble so stale values never match
  task xfer(input m, input w, input [13:0] a, input [13:0] d, output [13:0] q);
    @(posedge clk);
    #1;
    {prog_mode, prog_wr, prog_addr, prog_wdata} = {m, w, a, d};
    @(posedge clk);
    #1;
    q = (prog_rvalid === 1'b1) ? prog_rdata : 14'h0000;
    {prog_mode, prog_wr, prog_addr, prog_wdata} = {2'h0, ~a, ~d};
  endtask
  // Every protection pair gets the same code
  task burn(input [1:0] cp, input [5:0] f);
    logic [13:0] q;
    xfer(1, 1, 14'h2007, {cp, cp, cp, f[5:4], cp, f[3:0]}, q);
  endtask
endmodule

/* File: config_word_and_watchdog_bench.sv */
/*
 Self-checking bench for the configuration decoder and watchdog.
 Assumes the watchdog base count is shortened to four ticks.
*/
`timescale 1ns/1ps
module config_word_and_watchdog_bench;
  logic clk = 0, nrst = 0, sleeping = 0, clear_watchdog_instr = 0, sleep_instr = 0;
  logic wdt_osc_pin = 0, prescaler_to_wdt = 0, timeout_flag_set = 0;
  logic [2:0] prescale_sel = 3'h0;
  logic [1:0] mem_size = 2'h0;
  logic [10:0] fetch_addr = 11'h000;
  logic [13:0] q;
  wire prog_mode, prog_wr, prog_rvalid, addr_protected, brownout_reset_enable, powerup_delay_timer_on;
  wire watchdog_enable_fuse, high_speed_crystal_mode, standard_crystal_mode, low_power_crystal_mode;
  wire rc_osc_mode, wdt_reset, wdt_wake, timeout_flag_n;
  wire [13:0] prog_addr, prog_wdata, prog_rdata;
  int n_errors = 0, samples_checked = 0, n_rs = 0, n_wk = 0;
  always #4 clk = ~clk;
  // Event pulses last one cycle, so count them on every edge
  always @(posedge clk)
  begin
    if (wdt_reset === 1'b1) n_rs++;
    if (wdt_wake === 1'b1) n_wk++;
  end
  config_word_and_watchdog #(.WDT_BASE_TICKS(4)) dut (.clk, .nrst, .prog_mode, .prog_addr, .prog_wr,
    .prog_wdata, .prog_rdata, .prog_rvalid, .mem_size, .fetch_addr, .addr_protected, .brownout_reset_enable,
    .powerup_delay_timer_on, .watchdog_enable_fuse, .high_speed_crystal_mode, .standard_crystal_mode,
    .low_power_crystal_mode, .rc_osc_mode, .wdt_osc_pin, .sleeping, .clear_watchdog_instr, .sleep_instr,
    .prescaler_to_wdt, .prescale_sel, .timeout_flag_set, .wdt_reset, .wdt_wake, .timeout_flag_n);
  cfg_programmer pm (.clk, .prog_rvalid, .prog_rdata, .prog_mode, .prog_wr, .prog_addr, .prog_wdata);
  task chk(input string s, input logic [13:0] e, input logic [13:0] v);
    samples_checked++;
    if (v !== e)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", s, e, v);
    end
  endtask
  task rst;
    nrst = 0;
    repeat (3) @(posedge clk);
    #1 nrst = 1;
  endtask
  // Settle decode after a write, then read the word back
  task rd(input [13:0] e);
    repeat (2) @(posedge clk);
    pm.xfer(1, 0, 14'h2007, 14'h0000, q);
    chk("word", e, q);
  endtask
  task pr(input [1:0] m, input [10:0] a, input e);
    mem_size = m;
    fetch_addr = a;
    @(posedge clk);
    #1 chk("protect", e, addr_protected);
  endtask
  // Slow ticks so the two-stage sync always settles inside one tick
  task tick;
    wdt_osc_pin = 1;
    repeat (4) @(posedge clk);
    #1 wdt_osc_pin = 0;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task wd(input slp, input pre, input [2:0] sel, input use_slp, input int pt, input int e);
    int k, r0, w0;
    sleeping = slp;
    repeat (pt) tick;
    prescaler_to_wdt = pre;
    prescale_sel = sel;
    {sleep_instr, clear_watchdog_instr, timeout_flag_set} = {use_slp, !use_slp, 1'b1};
    @(posedge clk);
    #1 {sleep_instr, clear_watchdog_instr, timeout_flag_set} = 3'h0;
    r0 = n_rs;
    w0 = n_wk;
    k = 0;
    while (n_rs + n_wk == r0 + w0 && k < 20)
    begin
      tick;
      k++;
    end
    chk("ticks", e, k);
    chk("resets", !slp && e < 20, n_rs - r0);
    chk("wakes", slp && e < 20, n_wk - w0);
    chk("flag", e == 20, timeout_flag_n);
  endtask
  task t_erased;
    rd(14'h3FFF);
    chk("rc", 1, rc_osc_mode);
    chk("fuse", 1, watchdog_enable_fuse);
    chk("bor", 1, brownout_reset_enable);
    pm.xfer(0, 1, 14'h2007, 14'h0000, q);
    pm.xfer(1, 1, 14'h2006, 14'h0000, q);
    pm.xfer(0, 0, 14'h2007, 14'h0000, q);
    chk("refused read", 0, q);
    rd(14'h3FFF);
    $display("erased and refusal test done");
  endtask
  task t_hs;
    pm.burn(2'h2, 6'h2E);
    rd(14'h2AAE);
    chk("hs", 1, high_speed_crystal_mode);
    chk("bor", 0, brownout_reset_enable);
    chk("powerup_delay_timer", 0, powerup_delay_timer_on);
    pr(0, 11'h3FF, 0);
    pr(0, 11'h400, 1);
    pr(2, 11'h7FF, 0);
    pm.xfer(1, 1, 14'h2007, 14'h3FCF, q);
    repeat (2) @(posedge clk);
    pr(0, 11'h7FF, 0);
    $display("upper half test done");
  endtask
  task t_xt;
    rst;
    pm.burn(2'h1, 6'h3D);
    rd(14'h15DD);
    chk("xt", 1, standard_crystal_mode);
    chk("powerup_delay_timer", 1, powerup_delay_timer_on);
    pr(0, 11'h1FF, 0);
    pr(0, 11'h200, 1);
    pr(1, 11'h1FF, 0);
    pr(1, 11'h3FF, 1);
    pr(2, 11'h200, 0);
    wd(0, 0, 3'h0, 0, 0, 4);
    wd(1, 0, 3'h0, 1, 3, 4);
    wd(0, 1, 3'h1, 0, 2, 8);
    wd(1, 1, 3'h2, 0, 1, 16);
    $display("quarter and watchdog test done");
  endtask
  task t_lp;
    pm.burn(2'h0, 6'h00);
    rd(14'h0080);
    chk("lp", 1, low_power_crystal_mode);
    chk("powerup_delay_timer", 1, powerup_delay_timer_on);
    chk("fuse", 0, watchdog_enable_fuse);
    pr(2, 11'h1FF, 1);
    pr(0, 11'h000, 1);
    wd(0, 0, 3'h0, 0, 0, 20);
    $display("full protection test done");
  endtask
  task results;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Hang guard, about a hundred times the expected few microseconds
  initial
  begin
    #400000;
    n_errors++;
    results;
  end
  initial
  begin
    rst;
    t_erased;
    t_hs;
    t_xt;
    t_lp;
    results;
  end
endmodule
